/* logic/fcpl_flash_array.sv */
// Flash arrays: main region and configuration page, byte wide
`timescale 1ns/1ps
module fcpl_flash_array #(
    parameter int MAIN_BYTES = 17920,
    parameter int CFG_BYTES = 512,
    parameter int PAGE_BYTES = 512
) (
    // Clock, no reset
    input wire logic ref_clk_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic wr_cfg_in,
    input wire logic [14:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    // Erase port
    input wire logic page_erase_in,
    input wire logic erase_all_in,
    // Read port
    input wire logic [14:0] rd_addr_in,
    input wire logic rd_cfg_in,
    output logic [7:0] rd_data_out
);
    import fcpl_pkg::*;

    logic [7:0] main_mem [MAIN_BYTES];
    logic [7:0] cfg_mem [CFG_BYTES];

    // ==========================================
    // Flash writes clear bits only
    always_ff @(posedge ref_clk_in) begin
        if (erase_all_in) begin
            for (int i = 0; i < MAIN_BYTES; i++) begin
                main_mem[i] <= FCPL_BYTE_OPEN;
            end
            for (int i = 0; i < CFG_BYTES; i++) begin
                cfg_mem[i] <= FCPL_BYTE_OPEN;
            end
        end else if (page_erase_in) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (wr_cfg_in) begin
                    cfg_mem[i] <= FCPL_BYTE_OPEN;
                end else begin
                    main_mem[(int'(wr_addr_in) / PAGE_BYTES) * PAGE_BYTES + i] <= FCPL_BYTE_OPEN;
                end
            end
        end else if (wr_en_in) begin
            if (wr_cfg_in) begin
                cfg_mem[wr_addr_in[8:0]] <= cfg_mem[wr_addr_in[8:0]] & wr_data_in;
            end else begin
                main_mem[wr_addr_in] <= main_mem[wr_addr_in] & wr_data_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        rd_data_out <= rd_cfg_in ? cfg_mem[rd_addr_in[8:0]] : main_mem[rd_addr_in];
    end
endmodule : fcpl_flash_array

/* logic/fcpl_loader.sv */
// Configuration page loader and flash access gate
`timescale 1ns/1ps
// Function
// - Boot copies config page into registers
// - Main region 16k+1.5k, config page 512
// - Offset 0x20 loads protect count; 0xFF none
// - Readback byte not 0xFF blocks serial main access
// - Readback set once; cleared by erase all
// - Debug byte not 0xFF enables debug
// - System area altered by erases, redirected writes
// - Protected pages read-only for MCU only
// - 32 pages; count splits unprotected, protected
// - Start flag selects start address
// - Odd ones in top 16 NVM sets flag
// - Erase all restores access, clears page
// - Ready flag changes when boot readout ends
// - Redirect sends serial access to page
// - Debug bit settable while readback unlocked, never clearable, by MCU
module fcpl_loader (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Serial programmer
    input wire fcpl_pkg::fcpl_ser_req_s ser_req_in,
    output logic ser_rd_valid_out,
    output logic [7:0] ser_rd_data_out,
    output logic ser_refused_out,
    // MCU side
    input wire fcpl_pkg::fcpl_mcu_req_s mcu_req_in,
    input wire logic mcu_debug_set_in,
    input wire logic mcu_redirect_wr_in,
    input wire logic mcu_redirect_in,
    output logic mcu_refused_out,
    // Configuration and status
    output logic [7:0] flash_status_reg_out,
    output logic [7:0] flash_protect_config_reg_out,
    output logic [15:0] start_addr_out,
    output logic debug_features_on_out,
    output logic boot_done_out
);
    import fcpl_pkg::*;

    typedef enum logic [2:0] {
        FCPL_ST_UNPROT, FCPL_ST_READBACK, FCPL_ST_DEBUG, FCPL_ST_PARITY, FCPL_ST_RUN
    } fcpl_state_e;

    fcpl_state_e state_reg;
    logic [4:0] idx_reg;
    logic rd_pend_reg;
    logic parity_reg;
    logic [7:0] unprotected_page_count_reg;
    logic main_region_readback_disable_reg;
    logic debug_features_on_reg;
    logic protected_start_flag_reg;
    logic config_page_redirect_reg;
    logic flash_ready_n_reg;
    logic ser_rd_pend_reg;
    logic [7:0] rd_data;
    logic [14:0] rd_addr;
    logic rd_cfg;
    logic wr_en, wr_cfg, page_erase, erase_all;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic ser_ok, ser_run, mcu_ok, mcu_run;

    function automatic logic page_protected(input logic [14:0] addr, input logic [7:0] cnt);
        page_protected = (addr < 15'(FCPL_CODE_BYTES)) && (cnt < 8'(FCPL_CODE_PAGES))
            && ({3'h0, addr[13:9]} >= cnt);
    endfunction : page_protected

    // ==========================================
    // Flash storage
    fcpl_flash_array #(
        .MAIN_BYTES(FCPL_MAIN_BYTES),
        .CFG_BYTES(FCPL_CFG_BYTES),
        .PAGE_BYTES(FCPL_PAGE_BYTES)
    ) u_array (
        .ref_clk_in(ref_clk_in),
        .wr_en_in(wr_en),
        .wr_cfg_in(wr_cfg),
        .wr_addr_in(wr_addr),
        .wr_data_in(wr_data),
        .page_erase_in(page_erase),
        .erase_all_in(erase_all),
        .rd_addr_in(rd_addr),
        .rd_cfg_in(rd_cfg),
        .rd_data_out(rd_data)
    );

    // ==========================================
    // Boot and serial read addressing
    always_comb begin
        rd_cfg = 1'b1;
        rd_addr = 15'(FCPL_OFS_UNPROT);
        case (state_reg)
            FCPL_ST_UNPROT: rd_addr = 15'(FCPL_OFS_UNPROT);
            FCPL_ST_READBACK: rd_addr = 15'(FCPL_OFS_READBACK);
            FCPL_ST_DEBUG: rd_addr = 15'(FCPL_OFS_DEBUG);
            FCPL_ST_PARITY: begin
                rd_cfg = 1'b0;
                rd_addr = 15'(FCPL_MAIN_BYTES - FCPL_PARITY_BYTES) + {10'h0, idx_reg};
            end
            FCPL_ST_RUN: begin
                rd_cfg = config_page_redirect_reg;
                rd_addr = ser_req_in.addr;
            end
            default: rd_addr = 15'(FCPL_OFS_UNPROT);
        endcase
    end

    // ==========================================
    // Access gating
    always_comb begin
        ser_run = ser_req_in.valid && state_reg == FCPL_ST_RUN;
        mcu_run = mcu_req_in.valid && state_reg == FCPL_ST_RUN && !ser_run;
        ser_ok = !main_region_readback_disable_reg || ser_req_in.cmd == FCPL_CMD_ERASE_ALL
            || (ser_req_in.cmd == FCPL_CMD_READ && config_page_redirect_reg);
        if (ser_req_in.cmd == FCPL_CMD_READBACK_DIS && main_region_readback_disable_reg) begin
            ser_ok = 1'b0;
        end
        mcu_ok = !page_protected(mcu_req_in.addr, unprotected_page_count_reg);
        wr_en = 1'b0;
        wr_cfg = 1'b0;
        wr_addr = ser_req_in.addr;
        wr_data = ser_req_in.data;
        page_erase = 1'b0;
        erase_all = 1'b0;
        if (ser_run && ser_ok) begin
            wr_cfg = config_page_redirect_reg;
            case (ser_req_in.cmd)
                FCPL_CMD_WRITE: wr_en = 1'b1;
                FCPL_CMD_ERASE_PAGE: page_erase = 1'b1;
                FCPL_CMD_ERASE_ALL: erase_all = 1'b1;
                FCPL_CMD_READBACK_DIS: begin
                    wr_en = 1'b1;
                    wr_cfg = 1'b1;
                    wr_addr = 15'(FCPL_OFS_READBACK);
                    wr_data = FCPL_BYTE_CLOSED;
                end
                default: wr_en = 1'b0;
            endcase
        end else if (mcu_run && mcu_ok) begin
            wr_addr = mcu_req_in.addr;
            wr_data = mcu_req_in.data;
            wr_en = !mcu_req_in.erase;
            page_erase = mcu_req_in.erase;
        end
    end

    a_lock_gates_ser: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        main_region_readback_disable_reg && ser_run && ser_req_in.cmd != FCPL_CMD_ERASE_ALL
        |-> !wr_en && !page_erase) else $error("serial access passed the readback lock");
    a_protect_mcu: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        mcu_run && !mcu_ok |-> !wr_en && !page_erase) else $error("protected page altered");

    // ==========================================
    // Boot sequence
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= FCPL_ST_UNPROT;
            idx_reg <= 5'h00;
            rd_pend_reg <= 1'b0;
            parity_reg <= 1'b0;
        end else begin
            rd_pend_reg <= !rd_pend_reg && state_reg != FCPL_ST_RUN;
            if (rd_pend_reg) begin
                case (state_reg)
                    FCPL_ST_UNPROT: state_reg <= FCPL_ST_READBACK;
                    FCPL_ST_READBACK: state_reg <= FCPL_ST_DEBUG;
                    FCPL_ST_DEBUG: state_reg <= FCPL_ST_PARITY;
                    FCPL_ST_PARITY: begin
                        parity_reg <= parity_reg ^ (^rd_data);
                        idx_reg <= idx_reg + 5'h01;
                        if (idx_reg == 5'(FCPL_PARITY_BYTES - 1)) begin
                            state_reg <= FCPL_ST_RUN;
                        end
                    end
                    default: state_reg <= FCPL_ST_RUN;
                endcase
            end
        end
    end

    // ==========================================
    // Configuration registers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            unprotected_page_count_reg <= FCPL_PCR_RESET;
            main_region_readback_disable_reg <= 1'b1;
            debug_features_on_reg <= 1'b0;
        end else if (rd_pend_reg && state_reg == FCPL_ST_UNPROT) begin
            unprotected_page_count_reg <= rd_data;
        end else if (rd_pend_reg && state_reg == FCPL_ST_READBACK) begin
            main_region_readback_disable_reg <= rd_data != FCPL_BYTE_OPEN;
        end else if (rd_pend_reg && state_reg == FCPL_ST_DEBUG) begin
            debug_features_on_reg <= rd_data != FCPL_BYTE_OPEN;
        end else if (state_reg == FCPL_ST_RUN) begin
            if (mcu_debug_set_in && !main_region_readback_disable_reg) begin
                debug_features_on_reg <= 1'b1;
            end
            if (erase_all) begin
                main_region_readback_disable_reg <= 1'b0;
            end else if (ser_run && ser_ok && ser_req_in.cmd == FCPL_CMD_READBACK_DIS) begin
                main_region_readback_disable_reg <= 1'b1;
            end
        end
    end

    a_debug_sticky: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        state_reg == FCPL_ST_RUN && debug_features_on_reg |=> debug_features_on_reg)
        else $error("debug enable cleared while running");
    a_erase_unlock: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        erase_all |=> !main_region_readback_disable_reg) else $error("erase all left lock");
    a_readback_once: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        state_reg == FCPL_ST_RUN && main_region_readback_disable_reg && !erase_all
        |=> main_region_readback_disable_reg) else $error("readback lock reopened");

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            protected_start_flag_reg <= 1'b0;
            flash_ready_n_reg <= 1'b1;
            config_page_redirect_reg <= 1'b0;
        end else begin
            if (rd_pend_reg && state_reg == FCPL_ST_PARITY
                && idx_reg == 5'(FCPL_PARITY_BYTES - 1)) begin
                protected_start_flag_reg <= parity_reg ^ (^rd_data);
                flash_ready_n_reg <= 1'b0;
            end
            if (mcu_redirect_wr_in) begin
                config_page_redirect_reg <= mcu_redirect_in;
            end
        end
    end

    a_ready_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        flash_ready_n_reg == (state_reg != FCPL_ST_RUN)) else $error("ready flag out of step");

    // ==========================================
    // Registered outputs
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ser_rd_pend_reg <= 1'b0;
            ser_rd_valid_out <= 1'b0;
            ser_rd_data_out <= 8'h00;
            ser_refused_out <= 1'b0;
            mcu_refused_out <= 1'b0;
            start_addr_out <= FCPL_START_ADDR_ZERO;
            flash_status_reg_out <= FCPL_SR_RESET;
            flash_protect_config_reg_out <= FCPL_PCR_RESET;
            debug_features_on_out <= 1'b0;
            boot_done_out <= 1'b0;
        end else begin
            // Array data lags the accepted read by one cycle
            ser_rd_pend_reg <= ser_run && ser_ok && ser_req_in.cmd == FCPL_CMD_READ;
            ser_rd_valid_out <= ser_rd_pend_reg;
            if (ser_rd_pend_reg) begin
                ser_rd_data_out <= rd_data;
            end
            ser_refused_out <= ser_run && !ser_ok;
            mcu_refused_out <= mcu_run && !mcu_ok;
            start_addr_out <= (protected_start_flag_reg
                && unprotected_page_count_reg < 8'(FCPL_CODE_PAGES))
                ? {3'h0, unprotected_page_count_reg[4:0], 8'h00} << 1
                : FCPL_START_ADDR_ZERO;
            // Bits 5, 1 and 0 keep their reset values
            flash_status_reg_out[FCPL_SR_DEBUG] <= debug_features_on_reg;
            flash_status_reg_out[FCPL_SR_PSTART] <= protected_start_flag_reg;
            flash_status_reg_out[FCPL_SR_READY_N] <= flash_ready_n_reg;
            flash_status_reg_out[FCPL_SR_REDIRECT] <= config_page_redirect_reg;
            flash_status_reg_out[FCPL_SR_READBACK] <= main_region_readback_disable_reg;
            flash_protect_config_reg_out <= unprotected_page_count_reg;
            debug_features_on_out <= debug_features_on_reg;
            boot_done_out <= state_reg == FCPL_ST_RUN;
        end
    end

    a_start_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        boot_done_out && !protected_start_flag_reg |-> start_addr_out == FCPL_START_ADDR_ZERO)
        else $error("start address not zero");
endmodule : fcpl_loader

/* logic/fcpl_pkg.sv */
// Package for the flash configuration page loader
package fcpl_pkg;
    // ==========================================
    // Flash geometry
    localparam int FCPL_PAGE_BYTES = 512;
    localparam int FCPL_CODE_PAGES = 32;
    localparam int FCPL_CODE_BYTES = 16384;
    localparam int FCPL_NVM_BYTES = 1536;
    localparam int FCPL_MAIN_BYTES = FCPL_CODE_BYTES + FCPL_NVM_BYTES;
    localparam int FCPL_CFG_BYTES = 512;
    localparam int FCPL_SYS_BYTES = 32;
    localparam int FCPL_PARITY_BYTES = 16;
    // ==========================================
    // Configuration page offsets
    localparam logic [8:0] FCPL_OFS_SYS = 9'h000;
    localparam logic [8:0] FCPL_OFS_UNPROT = 9'h020;
    localparam logic [8:0] FCPL_OFS_RSV0 = 9'h021;
    localparam logic [8:0] FCPL_OFS_READBACK = 9'h023;
    localparam logic [8:0] FCPL_OFS_DEBUG = 9'h024;
    localparam logic [8:0] FCPL_OFS_RSV1 = 9'h025;
    localparam logic [7:0] FCPL_BYTE_OPEN = 8'hFF;
    localparam logic [7:0] FCPL_BYTE_CLOSED = 8'h00;
    // ==========================================
    // Status register bits and reset values
    localparam int FCPL_SR_DEBUG = 7;
    localparam int FCPL_SR_PSTART = 6;
    localparam int FCPL_SR_READY_N = 4;
    localparam int FCPL_SR_REDIRECT = 3;
    localparam int FCPL_SR_READBACK = 2;
    localparam int FCPL_SR_RSV1 = 1;
    localparam logic [7:0] FCPL_SR_RESET = 8'h16;
    localparam logic [7:0] FCPL_PCR_RESET = 8'hFF;
    localparam logic [15:0] FCPL_START_ADDR_ZERO = 16'h0000;
    // ==========================================
    // Serial commands
    typedef enum logic [2:0] {
        FCPL_CMD_READ,
        FCPL_CMD_WRITE,
        FCPL_CMD_ERASE_PAGE,
        FCPL_CMD_ERASE_ALL,
        FCPL_CMD_READBACK_DIS
    } fcpl_cmd_e;

    typedef struct packed {
        logic valid;
        fcpl_cmd_e cmd;
        logic [14:0] addr;
        logic [7:0] data;
    } fcpl_ser_req_s;

    typedef struct packed {
        logic valid;
        logic erase;
        logic [14:0] addr;
        logic [7:0] data;
    } fcpl_mcu_req_s;
endpackage : fcpl_pkg

/* sim/fcpl_loader_tb_top.sv */
// Self-checking bench for the configuration page loader
`timescale 1ns/1ps
module fcpl_loader_tb_top;
    import fcpl_pkg::*;
    logic ref_clk_in, rst_b_in, dbg_set, redir_wr, redir, rd_valid, refused;
    logic mcu_refused, boot_done, dbg_on;
    fcpl_ser_req_s ser_req;
    fcpl_mcu_req_s mcu_req;
    logic [7:0] rd_data, status, pcr;
    logic [15:0] start_addr;
    int mismatches = 0;
    int tests_run = 0;
    localparam logic [14:0] NVM_TOP = 15'(FCPL_MAIN_BYTES - 1);

    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    fcpl_loader dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ser_req_in(ser_req),
        .ser_rd_valid_out(rd_valid), .ser_rd_data_out(rd_data), .ser_refused_out(refused),
        .mcu_req_in(mcu_req), .mcu_debug_set_in(dbg_set), .mcu_redirect_wr_in(redir_wr),
        .mcu_redirect_in(redir), .mcu_refused_out(mcu_refused), .flash_status_reg_out(status),
        .flash_protect_config_reg_out(pcr), .start_addr_out(start_addr),
        .debug_features_on_out(dbg_on), .boot_done_out(boot_done));
    fcpl_prog_model prog (.ref_clk_in(ref_clk_in), .ser_req_out(ser_req),
        .ser_rd_valid_in(rd_valid), .ser_rd_data_in(rd_data), .ser_refused_in(refused));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run();
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic tick();
        @(posedge ref_clk_in);
        #5;
    endtask : tick

    task automatic boot();
        int n;
        tick();
        rst_b_in = 1'b0;
        repeat (8) tick();
        rst_b_in = 1'b1;
        n = 0;
        while (boot_done !== 1'b1 && n < 4000) begin
            tick();
            n++;
        end
        check(16'(boot_done), 16'h0001);
    endtask : boot

    task automatic set_redirect(input logic v);
        tick();
        redir_wr = 1'b1;
        redir = v;
        tick();
        redir_wr = 1'b0;
    endtask : set_redirect

    task automatic mcu_try(input logic [14:0] addr, input logic exp);
        logic seen;
        seen = 1'b0;
        tick();
        mcu_req = '{valid: 1'b1, erase: 1'b0, addr: addr, data: 8'h5A};
        tick();
        mcu_req = '{valid: 1'b0, erase: 1'b1, addr: ~addr, data: 8'hA5};
        repeat (8) begin
            seen = seen | (mcu_refused === 1'b1);
            tick();
        end
        check(16'(seen), 16'(exp));
    endtask : mcu_try

    task automatic sread(input logic [14:0] addr, input logic [7:0] exp, input logic exp_ref);
        logic [7:0] d;
        logic r;
        prog.xfer(FCPL_CMD_READ, addr, 8'h00, d, r);
        check(16'(r), 16'(exp_ref));
        if (!exp_ref) check(16'(d), 16'(exp));
    endtask : sread

    task automatic t_defaults();
        boot();
        set_redirect(1'b1);
        prog.erase_all_keep_sys();
        boot();
        check(16'(pcr), 16'h00FF);
        check(16'(status & 8'hD4), 16'h0000);
        check(16'(dbg_on), 16'h0000);
        check(start_addr, 16'h0000);
        tick();
        dbg_set = 1'b1;
        tick();
        dbg_set = 1'b0;
        repeat (2) tick();
        check(16'(status[7]), 16'h0001);
        check(16'(dbg_on), 16'h0001);
    endtask : t_defaults

    task automatic t_config();
        set_redirect(1'b1);
        prog.write_byte(15'(FCPL_OFS_UNPROT), 8'h0C);
        prog.write_byte(15'(FCPL_OFS_DEBUG), 8'h00);
        set_redirect(1'b0);
        prog.write_byte(NVM_TOP, 8'hFE);
        sread(NVM_TOP, 8'hFE, 1'b0);
        boot();
        check(16'(pcr), 16'h000C);
        check(16'(dbg_on), 16'h0001);
        check(16'(status[6]), 16'h0001);
        check(start_addr, 16'h1800);
        mcu_try(15'h1800, 1'b1);
        mcu_try(15'h17FF, 1'b0);
        sread(15'h1800, 8'hFF, 1'b0);
    endtask : t_config

    task automatic t_lock();
        logic [7:0] d;
        logic r;
        prog.lock();
        boot();
        check(16'(status[2]), 16'h0001);
        prog.xfer(FCPL_CMD_READBACK_DIS, 15'h0000, 8'h00, d, r);
        check(16'(r), 16'h0001);
        sread(15'h1800, 8'h00, 1'b1);
        set_redirect(1'b1);
        sread(15'(FCPL_OFS_UNPROT), 8'h0C, 1'b0);
    endtask : t_lock

    task automatic t_unlock();
        prog.erase_all_keep_sys();
        boot();
        check(16'(status[2]), 16'h0000);
        check(16'(pcr), 16'h00FF);
        set_redirect(1'b0);
        sread(NVM_TOP, 8'hFF, 1'b0);
    endtask : t_unlock

    initial begin
        rst_b_in = 1'b0;
        dbg_set = 1'b0;
        redir_wr = 1'b0;
        redir = 1'b0;
        mcu_req = '0;
        t_defaults();
        t_config();
        t_lock();
        t_unlock();
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge ref_clk_in);
        mismatches++;
        complete_run();
    end
endmodule : fcpl_loader_tb_top

/* sim/fcpl_prog_model.sv */
// Serial programmer model for the loader's programming port
`timescale 1ns/1ps
module fcpl_prog_model
    import fcpl_pkg::*;
(
    // Clock
    input wire logic ref_clk_in,
    // Programming port
    output fcpl_pkg::fcpl_ser_req_s ser_req_out,
    input wire logic ser_rd_valid_in,
    input wire logic [7:0] ser_rd_data_in,
    input wire logic ser_refused_in
);
    logic [7:0] sys_save [0:31];
    initial ser_req_out = '0;
    // ==========================================
    // One request, then a bounded wait for its answer
    task automatic xfer(input fcpl_cmd_e cmd, input logic [14:0] addr, input logic [7:0] data,
        output logic [7:0] rdata, output logic refused);
        rdata = 8'h00;
        refused = 1'b0;
        @(posedge ref_clk_in);
        #5;
        ser_req_out = '{valid: 1'b1, cmd: cmd, addr: addr, data: data};
        @(posedge ref_clk_in);
        #5;
        // Released address and data no longer carry the old value
        ser_req_out = '{valid: 1'b0, cmd: cmd, addr: ~addr, data: ~data};
        repeat (32) begin
            if (ser_rd_valid_in === 1'b1) rdata = ser_rd_data_in;
            if (ser_refused_in === 1'b1) refused = 1'b1;
            @(posedge ref_clk_in);
            #5;
        end
    endtask : xfer
    // ==========================================
    // Only the configurable bytes are ever written, reserved ones stay erased
    task automatic write_byte(input logic [14:0] addr, input logic [7:0] data);
        logic [7:0] d;
        logic r;
        xfer(FCPL_CMD_WRITE, addr, data, d, r);
    endtask : write_byte
    // Readback lock goes out as the final programming command
    task automatic lock();
        logic [7:0] d;
        logic r;
        xfer(FCPL_CMD_READBACK_DIS, 15'h0000, 8'h00, d, r);
    endtask : lock
    // System area saved across a full erase, caller has redirect on
    task automatic erase_all_keep_sys();
        logic [7:0] d;
        logic r;
        for (int i = 0; i < 32; i++) begin
            xfer(FCPL_CMD_READ, 15'(i), 8'h00, sys_save[i], r);
        end
        xfer(FCPL_CMD_ERASE_ALL, 15'h0000, 8'h00, d, r);
        for (int i = 0; i < 32; i++) begin
            xfer(FCPL_CMD_WRITE, 15'(i), sys_save[i], d, r);
        end
    endtask : erase_all_keep_sys
endmodule : fcpl_prog_model
